//--- core/fhsc_pkg.sv
// package with the types and constants of the status and command sequencer
package fhsc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int REQ_GAP_NS    = 24;
  localparam int REQ_GAP_CYC   =
    (REQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W         = 2;

  // command byte store
  localparam int PMEM_AW    = 4;
  localparam int PMEM_DEPTH = 16;

  // result buffer
  localparam int RBUF_DEPTH = 2;

  // reset values
  localparam logic [7:0] MSR_RESET  = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // main status register layout, msb first
  typedef struct packed {
    logic       host_request;
    logic       transfer_direction;
    logic       no_dma_flag;
    logic       controller_busy;
    logic [3:0] seek_busy;
  } fhsc_status_type;

  // result byte from the execution engine
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } fhsc_result_type;

  localparam fhsc_result_type RES_RESET = '{last: 1'b0, data: BYTE_RESET};

  // command phases
  typedef enum logic [1:0] {
    PH_IDLE    = 2'b00,
    PH_COMMAND = 2'b01,
    PH_EXEC    = 2'b10,
    PH_RESULT  = 2'b11
  } fhsc_phase_type;

endpackage : fhsc_pkg

//--- core/fhsc_param_mem.sv
// small store for the command and parameter bytes
`timescale 1ns/1ns
module fhsc_param_mem
  import fhsc_pkg::*;
(
  // clock
  input  wire logic               clk,
  // write port
  input  wire logic               we,
  input  wire logic [PMEM_AW-1:0] waddr,
  input  wire logic [7:0]         wdata,
  // registered read port
  input  wire logic [PMEM_AW-1:0] raddr,
  output logic      [7:0]         rdata
);

  logic [7:0] mem [PMEM_DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem[raddr];
  end

endmodule : fhsc_param_mem

//--- core/fhsc_res_buf.sv
// two-entry buffer for result bytes on their way to the processor
`timescale 1ns/1ns
module fhsc_res_buf
  import fhsc_pkg::*;
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rstn,
  // filling side
  input  wire logic            in_valid,
  input  wire fhsc_result_type in_data,
  output logic                 in_ready,
  // draining side
  output logic                 out_valid,
  output fhsc_result_type      out_data,
  input  wire logic            out_ready
);

  fhsc_result_type slot [RBUF_DEPTH];
  logic            wptr;
  logic            rptr;
  logic [1:0]      count;
  logic            push;
  logic            pop;
  logic [1:0]      next_count;

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign next_count = count + {1'b0, push} - {1'b0, pop};
  assign out_valid  = (count != 2'd0);
  assign out_data   = slot[rptr];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count    <= 2'd0;
      wptr     <= 1'b0;
      rptr     <= 1'b0;
      in_ready <= 1'b1;
      slot[0]  <= RES_RESET;
      slot[1]  <= RES_RESET;
    end
    else
    begin
      count    <= next_count;
      in_ready <= (next_count != 2'(RBUF_DEPTH));
      if (push)
      begin
        slot[wptr] <= in_data;
        wptr       <= ~wptr;
      end
      if (pop)
      begin
        rptr <= ~rptr;
      end
    end
  end

endmodule : fhsc_res_buf

//--- core/fhsc_core.sv
// main status register and three-phase command sequencer
`timescale 1ns/1ns
module fhsc_core
  import fhsc_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // processor bus pins
  input  wire logic               cs_n,
  input  wire logic               rd_n,
  input  wire logic               wr_n,
  input  wire logic               register_select,
  input  wire logic [7:0]         db_in,
  output logic      [7:0]         db_out,
  output logic                    db_oe_n,
  // drive and mode state from the execution engine
  input  wire logic [3:0]         drive_seek,
  input  wire logic               no_dma_mode,
  // command hand-off to the execution engine
  output logic                    exec_start,
  output logic      [7:0]         exec_opcode,
  output logic      [3:0]         cmd_count,
  input  wire logic [PMEM_AW-1:0] param_addr,
  output logic      [7:0]         param_data,
  input  wire logic               exec_done,
  input  wire logic               exec_has_result,
  // result bytes from the execution engine
  input  wire logic               res_valid,
  input  wire fhsc_result_type    res_data,
  output logic                    res_ready
);

  fhsc_phase_type  phase;
  fhsc_status_type main_status;
  logic [11:0]     pin_s1;
  logic [11:0]     pin_s2;
  logic            pin_cs;
  logic            pin_rd;
  logic            pin_wr;
  logic            pin_sel;
  logic            acc_rd;
  logic            acc_wr;
  logic            acc_rd_p;
  logic            acc_wr_p;
  logic            acc_sel;
  logic [7:0]      wr_byte;
  logic            rd_done;
  logic            wr_done;
  logic            take_wr;
  logic            take_rd;
  logic [GAP_W-1:0] gap;
  logic [3:0]      cmd_len;
  logic [3:0]      first_len;
  logic            buf_valid;
  fhsc_result_type buf_data;

  // total byte count of each command, opcode included
  function automatic logic [3:0] len_of(input logic [7:0] op);
    logic [3:0] n;
    n = 4'd1;
    unique case (op[4:0])
      5'h06, 5'h0c, 5'h05, 5'h09, 5'h02,
      5'h11, 5'h19, 5'h1d: n = 4'd9;
      5'h0d:               n = 4'd6;
      5'h03, 5'h0f:        n = 4'd3;
      5'h0a, 5'h07, 5'h04: n = 4'd2;
      default:             n = 4'd1;
    endcase
    return n;
  endfunction : len_of

  // two-stage synchroniser for the bus pins
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s1 <= 12'he_00;
      pin_s2 <= 12'he_00;
    end
    else
    begin
      pin_s1 <= {cs_n, rd_n, wr_n, register_select, db_in};
      pin_s2 <= pin_s1;
    end
  end

  assign pin_cs = ~pin_s2[11];
  assign pin_rd = ~pin_s2[10];
  assign pin_wr = ~pin_s2[9];
  assign pin_sel = pin_s2[8];

  // legal accesses only; write with select low is dropped
  assign acc_rd = pin_cs && pin_rd && !pin_wr;
  assign acc_wr = pin_cs && pin_wr && !pin_rd && pin_sel;

  // access tracking, a byte counts when its strobe ends
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_rd_p <= 1'b0;
      acc_wr_p <= 1'b0;
      acc_sel  <= 1'b0;
      wr_byte  <= BYTE_RESET;
    end
    else
    begin
      acc_rd_p <= acc_rd;
      acc_wr_p <= acc_wr;
      if (acc_rd)
      begin
        acc_sel <= pin_sel;
      end
      if (acc_wr)
      begin
        wr_byte <= pin_s2[7:0];
      end
    end
  end

  assign rd_done = acc_rd_p && !acc_rd;
  assign wr_done = acc_wr_p && !acc_wr;

  // a data access is taken only with matching ready and direction
  assign take_wr = wr_done && main_status.host_request
                   && !main_status.transfer_direction;
  assign take_rd = rd_done && acc_sel && main_status.host_request
                   && main_status.transfer_direction;

  assign first_len = len_of(wr_byte);

  // phase sequencing
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase <= PH_IDLE;
    end
    else
    begin
      unique case (phase)
        PH_IDLE:
        begin
          if (take_wr)
          begin
            phase <= (first_len == 4'd1) ? PH_EXEC : PH_COMMAND;
          end
        end
        PH_COMMAND:
        begin
          if (take_wr && (cmd_count + 4'd1 == cmd_len))
          begin
            phase <= PH_EXEC;
          end
        end
        PH_EXEC:
        begin
          if (exec_done)
          begin
            phase <= exec_has_result ? PH_RESULT : PH_IDLE;
          end
        end
        PH_RESULT:
        begin
          if (take_rd && buf_data.last)
          begin
            phase <= PH_IDLE;
          end
        end
      endcase
    end
  end

  // byte counting and hand-off to the execution engine
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_count   <= 4'd0;
      cmd_len     <= 4'd0;
      exec_opcode <= BYTE_RESET;
      exec_start  <= 1'b0;
    end
    else
    begin
      exec_start <= 1'b0;
      if (take_wr && phase == PH_IDLE)
      begin
        exec_opcode <= wr_byte;
        cmd_len     <= first_len;
        cmd_count   <= 4'd1;
        exec_start  <= (first_len == 4'd1);
      end
      else if (take_wr && phase == PH_COMMAND)
      begin
        cmd_count  <= cmd_count + 4'd1;
        exec_start <= (cmd_count + 4'd1 == cmd_len);
      end
    end
  end

  // recovery gap after each taken byte
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap <= '0;
    end
    else if (take_wr || take_rd)
    begin
      gap <= GAP_W'(REQ_GAP_CYC);
    end
    else if (gap != '0)
    begin
      gap <= gap - GAP_W'(1);
    end
  end

  // main status register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      main_status <= MSR_RESET;
    end
    else
    begin
      main_status.seek_busy          <= drive_seek;
      main_status.controller_busy    <= (phase != PH_IDLE);
      main_status.no_dma_flag        <= no_dma_mode;
      main_status.transfer_direction <= (phase == PH_RESULT);
      if (take_wr || take_rd || gap != '0)
      begin
        main_status.host_request <= 1'b0;
      end
      else
      begin
        unique case (phase)
          PH_IDLE, PH_COMMAND: main_status.host_request <= 1'b1;
          PH_EXEC:             main_status.host_request <= 1'b0;
          PH_RESULT:           main_status.host_request <= buf_valid;
        endcase
      end
    end
  end

  // data bus drive during reads
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      db_out  <= BYTE_RESET;
      db_oe_n <= 1'b1;
    end
    else
    begin
      db_oe_n <= ~acc_rd;
      if (acc_rd && !pin_sel)
      begin
        db_out <= main_status;
      end
      else if (acc_rd)
      begin
        db_out <= buf_data.data;
      end
    end
  end

  fhsc_param_mem u_param_mem (
    .clk   (clk),
    .we    (take_wr),
    .waddr (phase == PH_IDLE ? 4'd0 : cmd_count),
    .wdata (wr_byte),
    .raddr (param_addr),
    .rdata (param_data)
  );

  fhsc_res_buf u_res_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (res_valid),
    .in_data   (res_data),
    .in_ready  (res_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (take_rd)
  );

  default clocking tick @(posedge clk); endclocking
  default disable iff (!rstn);

  seek_follow_a: assert property (
    main_status.seek_busy == $past(drive_seek))
    else $error("seek flags do not follow drive seek state");
  busy_phase_a: assert property (
    main_status.controller_busy == $past(phase != PH_IDLE))
    else $error("busy flag does not match command activity");
  dma_flag_a: assert property (
    main_status.no_dma_flag == $past(no_dma_mode))
    else $error("no dma flag does not follow mode");
  dir_result_a: assert property (
    $rose(phase == PH_RESULT) |=> main_status.transfer_direction)
    else $error("direction not set in result phase");
  req_ready_a: assert property (
    main_status.host_request && main_status.transfer_direction
    |-> $past(buf_valid))
    else $error("request raised with no result byte ready");
  req_gap_a: assert property (
    take_wr || take_rd |=> !main_status.host_request [*4])
    else $error("request not held low after a taken byte");
  start_full_a: assert property (
    exec_start |-> phase == PH_EXEC && cmd_count == cmd_len)
    else $error("execution started before all bytes taken");
  result_entry_a: assert property (
    $rose(phase == PH_RESULT) |-> $past(exec_done))
    else $error("result phase entered without execution end");
  status_read_a: assert property (
    acc_rd && !pin_sel |=> !db_oe_n && db_out == $past(main_status))
    else $error("status read returned wrong value");
  bad_write_a: assert property (
    pin_cs && pin_wr && !pin_sel ##1 acc_wr_p |-> 1'b0)
    else $error("write with select low was accepted");

  cmd_run_c: cover property (phase == PH_COMMAND ##[1:300] exec_start);
  result_end_c: cover property (phase == PH_RESULT ##1 phase == PH_IDLE);
  status_rd_c: cover property (acc_rd && !pin_sel && phase == PH_EXEC);
  buf_full_c: cover property (!res_ready && res_valid);

endmodule : fhsc_core

//--- tb/fhsc_host.sv
// processor model that polls status and moves bytes through the data port
`timescale 1ns/1ns
module fhsc_host
(
  // clock
  input  wire logic       clk,
  // bus pins
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            register_select,
  output logic [7:0]      db_in,
  input  wire logic [7:0] db_out,
  input  wire logic       db_oe_n,
  // read results
  output logic            got,
  output logic [7:0]      got_val
);
  initial
  begin
    {cs_n, rd_n, wr_n} = 3'h7;
    register_select = 1'b0;
    db_in = 8'hff;
    got = 1'b0;
    got_val = 8'h00;
  end

  // read cycle: strobe held four edges, data taken at the last one
  task automatic rd(input logic sel, input logic chk,
                    output logic [7:0] val);
    @(posedge clk);
    {cs_n, rd_n}    <= 2'h0;
    register_select <= sel;
    repeat (4) @(posedge clk);
    val = db_oe_n ? ~db_out : db_out;
    got_val      <= db_oe_n ? ~db_out : db_out;
    got          <= chk;
    {cs_n, rd_n} <= 2'h3;
    @(posedge clk);
    got <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : rd

  // write cycle: bus shows the inverse once released
  task automatic wr(input logic sel, input logic [7:0] b);
    @(posedge clk);
    {cs_n, wr_n}    <= 2'h0;
    register_select <= sel;
    db_in           <= b;
    repeat (4) @(posedge clk);
    {cs_n, wr_n} <= 2'h3;
    db_in        <= ~b;
  endtask : wr

  // poll status until the port is ready in the wanted direction
  task automatic wait_ready(input logic dir);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 50 && !(s[7] === 1'b1 && s[6] === dir); i++)
      rd(1'b0, 1'b0, s);
  endtask : wait_ready
endmodule : fhsc_host

//--- tb/test_floppy_host_status_cmd_phase.sv
// self-checking bench for the status and command sequencer
`timescale 1ns/1ns
module test_floppy_host_status_cmd_phase;
  import fhsc_pkg::*;
  logic            clk, rstn, cs_n, rd_n, wr_n, register_select;
  logic            db_oe_n, got, no_dma_mode, exec_start, exec_done;
  logic            exec_has_result, res_valid, res_ready;
  logic [7:0]      db_in, db_out, got_val, exec_opcode, param_data;
  logic [3:0]      drive_seek, cmd_count, param_addr;
  fhsc_result_type res_data;
  logic [7:0]      rd_q[$];
  logic [11:0]     cmd_q[$];
  int              error_cnt, tests_run, cycles;
  int              seed;

  fhsc_core u_fhsc_core (.clk(clk), .rstn(rstn), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .register_select(register_select),
    .db_in(db_in), .db_out(db_out), .db_oe_n(db_oe_n),
    .drive_seek(drive_seek), .no_dma_mode(no_dma_mode),
    .exec_start(exec_start), .exec_opcode(exec_opcode),
    .cmd_count(cmd_count), .param_addr(param_addr),
    .param_data(param_data), .exec_done(exec_done),
    .exec_has_result(exec_has_result), .res_valid(res_valid),
    .res_data(res_data), .res_ready(res_ready));

  fhsc_host u_fhsc_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .register_select(register_select), .db_in(db_in),
    .db_out(db_out), .db_oe_n(db_oe_n), .got(got), .got_val(got_val));

  always #4 clk = ~clk;

  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [11:0] g, input logic [11:0] e);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp

  // checked read: expectation noted first, compared by the watcher
  task automatic chk(input logic sel, input logic [7:0] e);
    logic [7:0] v;
    rd_q.push_back(e);
    u_fhsc_host.rd(sel, 1'b1, v);
  endtask : chk

  task automatic pulse_done(input logic has);
    @(posedge clk);
    exec_done       <= 1'b1;
    exec_has_result <= has;
    @(posedge clk);
    exec_done <= 1'b0;
  endtask : pulse_done

  task automatic run_cmd(input logic [7:0] op, input int len,
                         input int nres);
    logic [7:0] b [16];
    for (int i = 0; i < len; i++)
    begin
      b[i] = (i == 0) ? op : 8'($random(seed));
      if (i == len - 1)
        cmd_q.push_back({op, 4'(len)});
      u_fhsc_host.wait_ready(1'b0);
      u_fhsc_host.wr(1'b1, b[i]);
      if (i == len - 1)
        for (int t = 0; t < 20 && exec_start !== 1'b1; t++)
          @(negedge clk);
      if (i == 0)
      begin
        @(posedge clk);
        chk(1'b0, 8'h10);
      end
    end
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk);
      param_addr <= 4'(i);
      repeat (2) @(negedge clk);
      cmp({4'h0, param_data}, {4'h0, b[i]});
    end
    chk(1'b0, 8'h10);
    if (nres == 0)
      pulse_done(1'b0);
    else
      fork
        begin
          for (int i = 0; i < nres; i++)
          begin
            res_valid <= 1'b1;
            res_data  <= '{last: (i == nres - 1),
                           data: 8'(8'h5a + i * 8'h11)};
            for (int t = 0; t < 200; t++)
            begin
              @(posedge clk);
              if (res_ready === 1'b1)
                break;
            end
          end
          res_valid <= 1'b0;
        end
        begin
          repeat (8) @(posedge clk);
          cmp({11'h000, res_ready}, 12'h000);
          pulse_done(1'b1);
          chk(1'b0, 8'hd0);
          for (int i = 0; i < nres; i++)
          begin
            u_fhsc_host.wait_ready(1'b1);
            chk(1'b1, 8'(8'h5a + i * 8'h11));
          end
        end
      join
    repeat (4) @(posedge clk);
    chk(1'b0, 8'h80);
  endtask : run_cmd

  // watcher: every result takes the oldest note off its queue
  always @(posedge clk)
  begin
    if (got === 1'b1)
      cmp({4'h0, got_val}, {4'h0, rd_q.pop_front()});
    if (exec_start === 1'b1)
      cmp({exec_opcode, cmd_count}, cmd_q.pop_front());
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  initial
  begin
    seed = 32'h4d93_e6ff;
    clk = 1'b0;
    rstn = 1'b0;
    drive_seek = 4'h0;
    no_dma_mode = 1'b0;
    param_addr = 4'h0;
    exec_done = 1'b0;
    exec_has_result = 1'b0;
    res_valid = 1'b0;
    res_data = RES_RESET;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(1'b0, 8'h80);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      drive_seek  <= 4'h1 << i;
      no_dma_mode <= i[0];
      chk(1'b0, {2'h2, i[0], 1'b0, 4'h1 << i});
    end
    @(posedge clk);
    drive_seek  <= 4'h0;
    no_dma_mode <= 1'b0;
    u_fhsc_host.wr(1'b0, 8'h03);
    chk(1'b0, 8'h80);
    run_cmd(8'h46, 9, 3);
    run_cmd(8'h0d, 6, 0);
    run_cmd(8'h0f, 3, 0);
    run_cmd(8'h07, 2, 0);
    run_cmd(8'h08, 1, 0);
    complete_run();
  end
endmodule : test_floppy_host_status_cmd_phase
